// ### hw/flash_table_access.sv
// Table read/write and self-timed erase/program sequencer for embedded flash.
// Assumes an AHB-Lite master on hclk, a flash array answering reads in one
// cycle, and a separate warm reset pulse for resets other than power-on.
//
// Local design decisions: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "flash_table_access_regs.svh"

// Operation
// - erase bit erases pointer row, clears on completion
// - erase bit clear means program only
// - early end or improper start sets error
// - error flag clears on normal completion
// - write enable gates every erase/program cycle
// - start bit launches cycle, hardware clears it
// - software cannot clear start bit
// - control bits 7..5 and 0 read zero
// - 8-bit latch carries each moved byte
// - pointer is upper:high:low, 22 bits
// - top pointer bit selects configuration space
// - auto update touches low 21 bits only
// - four pointer modes: keep, post inc/dec, pre inc
// - table read uses all 22 pointer bits
// - table write picks holding register by low bits
// - program block chosen by pointer bits 21..10
// - erase block chosen by top 12 bits
// - one table read moves exactly one byte
// - pointer bit 0 picks high or low byte
// - fetches stall while cycle runs
// - unlock register reads all zeros
// - holding registers kept after program cycle
module flash_table_access
    import flash_table_access_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = 1000
)
(
    // Clock and reset
    input  wire logic                                 hclk,
    input  wire logic                                 hresetn,
    // AHB-Lite slave
    input  wire logic                                 hsel,
    input  wire logic [31:0]                          haddr,
    input  wire logic [1:0]                           htrans,
    input  wire logic                                 hwrite,
    input  wire logic [2:0]                           hsize,
    input  wire logic [31:0]                          hwdata,
    input  wire logic                                 hready,
    output logic                                      hreadyout,
    output logic                                      hresp,
    output logic [31:0]                               hrdata,
    // Flash array side
    output flash_table_access_pkg::flash_cmd_type     flash_cmd,
    input  wire logic [15:0]                          flash_rd_word,
    input  wire logic [5:0]                           hold_rd_idx,
    output logic [7:0]                                hold_rd_data,
    // Core side
    input  wire logic                                 warm_reset,
    output logic                                      fetch_stall
);

    import flash_table_access_pkg::*;

    localparam int unsigned CNT_W = 32;

    // Whole block state
    typedef struct packed {
        logic                   dp_valid;
        logic                   dp_write;
        logic [4:0]             dp_addr;
        seq_state_type          seq;
        unlock_type             unlock;
        logic                   erase_sel;
        logic                   error;
        logic                   program_write_enable;
        logic                   start;
        logic                   cycle_erase;
        logic                   cmd_pulse;
        logic [7:0]             latch;
        logic [21:0]            ptr;
        logic [21:0]            acc_addr;
        logic [CNT_W-1:0]       timer;
        logic [63:0][7:0]       hold;
    } state_type;

    state_type st_r;
    state_type st_nxt;

    // Pointer step confined to low 21 bits
    function automatic logic [21:0] ptr_step(input logic [21:0] p, input logic down);
        logic [20:0] low;
        low = down ? (p[20:0] - 21'h000001) : (p[20:0] + 21'h000001);
        return {p[21], low};
    endfunction

    // Byte lane of a 32-bit write word
    function automatic logic [7:0] wbyte(input logic [31:0] d);
        return d[7:0];
    endfunction

    logic       bus_wr;
    logic       busy;
    logic [7:0] ctrl_view;
    logic [7:0] cmd_view;
    logic [7:0] wdat;

    // Busy while any sequencer activity is pending
    assign busy      = (st_r.seq != SEQ_IDLE);
    assign hreadyout = !(st_r.dp_valid && busy);
    assign hresp     = 1'b0;
    assign bus_wr    = st_r.dp_valid && st_r.dp_write && hreadyout;
    assign wdat      = wbyte(hwdata);
    assign fetch_stall = (st_r.seq == SEQ_PROG);

    // Control view with unimplemented bits as zero
    always_comb
    begin
        ctrl_view = 8'h00;
        ctrl_view[`FTA_CTRL_ERASE] = st_r.erase_sel;
        ctrl_view[`FTA_CTRL_ERROR] = st_r.error;
        ctrl_view[`FTA_CTRL_PROGRAM_WRITE_ENABLE]  = st_r.program_write_enable;
        ctrl_view[`FTA_CTRL_START] = st_r.start;
        cmd_view = 8'h00;
        cmd_view[`FTA_CMD_BUSY] = busy;
    end

    // Read data mux
    always_comb
    begin
        hrdata = 32'h00000000;
        if (st_r.dp_valid && !st_r.dp_write)
        begin
            case (st_r.dp_addr)
                `FTA_OFF_CTRL:      hrdata = {24'h000000, ctrl_view};
                `FTA_OFF_UNLOCK:    hrdata = 32'h00000000;
                `FTA_OFF_LATCH:     hrdata = {24'h000000, st_r.latch};
                `FTA_OFF_PTR_LOW:   hrdata = {24'h000000, st_r.ptr[7:0]};
                `FTA_OFF_PTR_HIGH:  hrdata = {24'h000000, st_r.ptr[15:8]};
                `FTA_OFF_PTR_UPPER: hrdata = {26'h0, st_r.ptr[21:16]};
                `FTA_OFF_TABLE_CMD: hrdata = {24'h000000, cmd_view};
                default:            hrdata = 32'h00000000;
            endcase
        end
    end

    // Flash array command and holding read port
    always_comb
    begin
        flash_cmd             = '0;
        flash_cmd.rd_en       = (st_r.seq == SEQ_RD_ISS);
        flash_cmd.rd_addr     = st_r.acc_addr;
        flash_cmd.prog_start  = st_r.cmd_pulse && !st_r.cycle_erase;
        flash_cmd.erase_start = st_r.cmd_pulse && st_r.cycle_erase;
        flash_cmd.block       = st_r.ptr[21:`FTA_BLOCK_LSB];
        hold_rd_data          = st_r.hold[hold_rd_idx];
    end

    // Next-state logic
    always_comb
    begin
        logic [21:0]  addr_v;
        ptr_mode_type mode_v;
        addr_v = 22'h000000;
        mode_v = PTR_KEEP;
        st_nxt = st_r;
        st_nxt.cmd_pulse = 1'b0;

        // Address phase capture
        if (hready)
        begin
            st_nxt.dp_valid = hsel && htrans[1];
            st_nxt.dp_write = hwrite;
            st_nxt.dp_addr  = haddr[4:0];
        end

        // Sequencer
        case (st_r.seq)
            SEQ_IDLE:
            begin
            end
            SEQ_RD_ISS:
            begin
                st_nxt.seq = SEQ_RD_TAKE;
            end
            SEQ_RD_TAKE:
            begin
                // One byte per read, chosen by address bit 0
                st_nxt.latch = st_r.acc_addr[0] ? flash_rd_word[15:8]
                                                : flash_rd_word[7:0];
                st_nxt.seq   = SEQ_IDLE;
            end
            SEQ_PROG:
            begin
                if (st_r.timer == 32'h00000001)
                begin
                    st_nxt.seq   = SEQ_IDLE;
                    st_nxt.start = 1'b0;
                    st_nxt.error = 1'b0;
                    if (st_r.cycle_erase)
                    begin
                        st_nxt.erase_sel = 1'b0;
                    end
                end
                st_nxt.timer = st_r.timer - 32'h00000001;
            end
            default:
            begin
                st_nxt.seq = SEQ_IDLE;
            end
        endcase

        // Register writes, accepted only when not stalled
        if (bus_wr)
        begin
            if (st_r.dp_addr != `FTA_OFF_UNLOCK)
            begin
                st_nxt.unlock = UNL_NONE;
            end
            case (st_r.dp_addr)
                `FTA_OFF_CTRL:
                begin
                    st_nxt.erase_sel = wdat[`FTA_CTRL_ERASE];
                    st_nxt.error     = wdat[`FTA_CTRL_ERROR];
                    st_nxt.program_write_enable      = wdat[`FTA_CTRL_PROGRAM_WRITE_ENABLE];
                    if (wdat[`FTA_CTRL_START])
                    begin
                        if (wdat[`FTA_CTRL_PROGRAM_WRITE_ENABLE] && st_r.unlock == UNL_BOTH)
                        begin
                            st_nxt.start       = 1'b1;
                            st_nxt.seq         = SEQ_PROG;
                            st_nxt.cycle_erase = wdat[`FTA_CTRL_ERASE];
                            st_nxt.cmd_pulse   = 1'b1;
                            st_nxt.timer       = PROG_CYCLES;
                        end
                        else
                        begin
                            st_nxt.error = 1'b1;
                        end
                    end
                end
                `FTA_OFF_UNLOCK:
                begin
                    if (wdat == `FTA_KEY_FIRST)
                    begin
                        st_nxt.unlock = UNL_FIRST;
                    end
                    else if (wdat == `FTA_KEY_SECOND && st_r.unlock == UNL_FIRST)
                    begin
                        st_nxt.unlock = UNL_BOTH;
                    end
                    else
                    begin
                        st_nxt.unlock = UNL_NONE;
                    end
                end
                `FTA_OFF_LATCH:
                begin
                    st_nxt.latch = wdat;
                end
                `FTA_OFF_PTR_LOW:
                begin
                    st_nxt.ptr[7:0] = wdat;
                end
                `FTA_OFF_PTR_HIGH:
                begin
                    st_nxt.ptr[15:8] = wdat;
                end
                `FTA_OFF_PTR_UPPER:
                begin
                    st_nxt.ptr[21:16] = wdat[5:0];
                end
                `FTA_OFF_TABLE_CMD:
                begin
                    // Access address and pointer update by mode
                    mode_v = ptr_mode_type'(wdat[1:0]);
                    case (mode_v)
                        PTR_KEEP:
                        begin
                            addr_v = st_r.ptr;
                        end
                        PTR_POST_INC:
                        begin
                            addr_v = st_r.ptr;
                            st_nxt.ptr = ptr_step(st_r.ptr, 1'b0);
                        end
                        PTR_POST_DEC:
                        begin
                            addr_v = st_r.ptr;
                            st_nxt.ptr = ptr_step(st_r.ptr, 1'b1);
                        end
                        PTR_PRE_INC:
                        begin
                            addr_v = ptr_step(st_r.ptr, 1'b0);
                            st_nxt.ptr = addr_v;
                        end
                        default:
                        begin
                            addr_v = st_r.ptr;
                        end
                    endcase
                    if (wdat[`FTA_CMD_WRITE])
                    begin
                        st_nxt.hold[addr_v[5:0]] = st_r.latch;
                    end
                    else
                    begin
                        st_nxt.acc_addr = addr_v;
                        st_nxt.seq      = SEQ_RD_ISS;
                    end
                end
                default:
                begin
                end
            endcase
        end

        // Warm reset cuts a running cycle short; holding data untouched
        if (warm_reset)
        begin
            if (st_r.seq == SEQ_PROG)
            begin
                st_nxt.error = 1'b1;
            end
            st_nxt.seq         = SEQ_IDLE;
            st_nxt.start       = 1'b0;
            st_nxt.program_write_enable        = 1'b0;
            st_nxt.erase_sel   = 1'b0;
            st_nxt.unlock      = UNL_NONE;
            st_nxt.cmd_pulse   = 1'b0;
            st_nxt.dp_valid    = 1'b0;
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_ERASE_BIT_CLEARS: assert property (
        (st_r.seq == SEQ_PROG && st_r.cycle_erase && st_r.timer == 32'h00000001 && !warm_reset)
        |=> !st_r.erase_sel && !st_r.start)
        else $error("erase select not cleared at erase end");

    AST_PROG_NO_ERASE: assert property (
        flash_cmd.prog_start |-> !flash_cmd.erase_start && !st_r.cycle_erase)
        else $error("program start carried an erase");

    AST_IMPROPER_ERROR: assert property (
        (bus_wr && st_r.dp_addr == `FTA_OFF_CTRL && wdat[`FTA_CTRL_START]
         && st_r.unlock != UNL_BOTH && !warm_reset)
        |=> st_r.error && !st_r.start)
        else $error("improper start did not flag error");

    AST_DONE_CLEARS_ERROR: assert property (
        (st_r.seq == SEQ_PROG ##1 st_r.seq == SEQ_IDLE && $past(!warm_reset))
        |-> !st_r.error || $past(bus_wr))
        else $error("error flag set after normal completion");

    AST_PROGRAM_WRITE_ENABLE_GATES: assert property (
        $rose(st_r.seq == SEQ_PROG) |-> st_r.program_write_enable && st_r.start && $past(st_r.unlock == UNL_BOTH))
        else $error("cycle started without enable and unlock");

    AST_START_HELD: assert property (
        (st_r.seq == SEQ_PROG && st_r.timer > 32'h00000001 && !warm_reset)
        |=> st_r.start && fetch_stall)
        else $error("start bit dropped before cycle end");

    AST_UNUSED_ZERO: assert property (
        (st_r.dp_valid && !st_r.dp_write && st_r.dp_addr == `FTA_OFF_CTRL)
        |-> hrdata[7:5] == 3'h0 && hrdata[0] == 1'b0)
        else $error("unimplemented control bits not zero");

    AST_TOP_BIT_KEPT: assert property (
        (bus_wr && st_r.dp_addr == `FTA_OFF_TABLE_CMD && !warm_reset)
        |=> st_r.ptr[21] == $past(st_r.ptr[21]))
        else $error("table operation changed pointer top bit");

    AST_READ_ONE_BYTE: assert property (
        (st_r.seq == SEQ_RD_ISS && !warm_reset) |=> st_r.seq == SEQ_RD_TAKE ##1 st_r.seq == SEQ_IDLE)
        else $error("table read did not finish in two cycles");

    AST_UNLOCK_ZERO: assert property (
        (st_r.dp_valid && !st_r.dp_write && st_r.dp_addr == `FTA_OFF_UNLOCK)
        |-> hrdata == 32'h00000000)
        else $error("unlock register read not zero");

endmodule

// ### include/flash_table_access_pkg.sv
// Types shared by the flash table access block.
// Assumes flash_table_access_regs.svh for numeric constants.
package flash_table_access_pkg;

    // Pointer update applied by a table operation
    typedef enum logic [1:0] {
        PTR_KEEP     = 2'h0,
        PTR_POST_INC = 2'h1,
        PTR_POST_DEC = 2'h2,
        PTR_PRE_INC  = 2'h3
    } ptr_mode_type;

    // Sequencer states, Gray along idle, read issue, read take
    typedef enum logic [1:0] {
        SEQ_IDLE    = 2'h0,
        SEQ_RD_ISS  = 2'h1,
        SEQ_RD_TAKE = 2'h3,
        SEQ_PROG    = 2'h2
    } seq_state_type;

    // Unlock sequence progress
    typedef enum logic [1:0] {
        UNL_NONE  = 2'h0,
        UNL_FIRST = 2'h1,
        UNL_BOTH  = 2'h3
    } unlock_type;

    // Flash array command bundle
    typedef struct packed {
        logic        rd_en;
        logic [21:0] rd_addr;
        logic        prog_start;
        logic        erase_start;
        logic [11:0] block;
    } flash_cmd_type;

endpackage

// ### include/flash_table_access_regs.svh
// Register offsets, field positions and reset values of the flash table block.
// Assumes a 32-bit AHB-Lite slave, one aligned word per register.
`ifndef FLASH_TABLE_ACCESS_REGS_SVH
`define FLASH_TABLE_ACCESS_REGS_SVH

// Byte offsets within the block's window
`define FTA_OFF_CTRL      5'h00
`define FTA_OFF_UNLOCK    5'h04
`define FTA_OFF_LATCH     5'h08
`define FTA_OFF_PTR_LOW   5'h0C
`define FTA_OFF_PTR_HIGH  5'h10
`define FTA_OFF_PTR_UPPER 5'h14
`define FTA_OFF_TABLE_CMD 5'h18

// Control register fields
`define FTA_CTRL_ERASE    4
`define FTA_CTRL_ERROR    3
`define FTA_CTRL_PROGRAM_WRITE_ENABLE     2
`define FTA_CTRL_START    1

// Table command fields: mode in [1:0], direction in bit 2, busy in bit 7
`define FTA_CMD_MODE_LSB  0
`define FTA_CMD_WRITE     2
`define FTA_CMD_BUSY      7

// Unlock key bytes
`define FTA_KEY_FIRST     8'h55
`define FTA_KEY_SECOND    8'hAA

// Reset values
`define FTA_CTRL_RESET    8'h00
`define FTA_LATCH_RESET   8'h00
`define FTA_PTR_RESET     22'h000000

// Pointer geometry
`define FTA_PTR_W         22
`define FTA_PTR_LOW_W     21
`define FTA_HOLD_DEPTH    64
`define FTA_BLOCK_LSB     10

`endif

// ### verification/flash_array_model.sv
// Behavioural flash array that answers the sequencer's byte reads.
// Assumes reads are sampled the cycle after rd_en; word = {lo ^ C3, lo}.
`timescale 1ns/1ns
module flash_array_model
    import flash_table_access_pkg::*;
(
    // Clock and reset
    input  wire logic                             hclk,
    input  wire logic                             hresetn,
    // Array port
    input  wire flash_table_access_pkg::flash_cmd_type flash_cmd,
    output logic [15:0]                           flash_rd_word
);
    logic        valid_r;
    logic [21:0] addr_r;
    logic        flip_r;
    logic [7:0]  lo;

    // Capture read address; toggle filler outside reads
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            valid_r <= 1'b0;
            addr_r  <= 22'h000000;
            flip_r  <= 1'b0;
        end
        else
        begin
            valid_r <= flash_cmd.rd_en;
            addr_r  <= flash_cmd.rd_addr;
            flip_r  <= ~flip_r;
        end
    end

    // Word content depends on address bits 21 and 8..1 only
    assign lo = addr_r[8:1] ^ {addr_r[21], 7'h00};
    assign flash_rd_word = valid_r ? {lo ^ 8'hC3, lo} : {16{flip_r}};
endmodule

// ### verification/flash_table_access_test.sv
// Self-checking bench for the flash table access block.
// Assumes one AHB-Lite master (this bench) and the behavioural array model.
`timescale 1ns/1ns
`include "flash_table_access_regs.svh"
module flash_table_access_test
    import flash_table_access_pkg::*;
;
    localparam int unsigned PROG = 4;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    flash_cmd_type flash_cmd;
    logic [15:0] flash_rd_word;
    logic [5:0]  hold_rd_idx = 6'h00;
    logic [7:0]  hold_rd_data;
    logic        warm_reset = 1'b0;
    logic        fetch_stall;
    int          miscompares = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          n_prog = 0;
    int          n_erase = 0;
    int          n_stall = 0;
    logic [11:0] blk = 12'h000;
    logic [21:0] p = 22'h000000;
    logic [31:0] r;

    flash_table_access #(.PROG_CYCLES(PROG)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .flash_cmd(flash_cmd),
        .flash_rd_word(flash_rd_word), .hold_rd_idx(hold_rd_idx),
        .hold_rd_data(hold_rd_data), .warm_reset(warm_reset), .fetch_stall(fetch_stall));

    flash_array_model i_array (.hclk(hclk), .hresetn(hresetn), .flash_cmd(flash_cmd),
        .flash_rd_word(flash_rd_word));

    // Clock
    always #5 hclk = ~hclk;

    // Count array commands and stall cycles; watchdog
    always @(posedge hclk)
    begin
        cycles++;
        if (flash_cmd.prog_start === 1'b1) n_prog++;
        if (flash_cmd.erase_start === 1'b1) n_erase++;
        if (flash_cmd.prog_start === 1'b1 || flash_cmd.erase_start === 1'b1) blk = flash_cmd.block;
        if (fetch_stall === 1'b1) n_stall++;
        if (cycles == 20000)
        begin
            miscompares++;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One single AHB-Lite transfer; waits on hready in both phases
    task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d,
                       output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {27'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] x;
        bus(a, 1'b1, d, x);
    endtask

    task automatic unlock();
        wr(`FTA_OFF_UNLOCK, `FTA_KEY_FIRST);
        wr(`FTA_OFF_UNLOCK, `FTA_KEY_SECOND);
    endtask

    function automatic logic [7:0] byte_at(input logic [21:0] a);
        logic [7:0] lo;
        lo = a[8:1] ^ {a[21], 7'h00};
        return a[0] ? lo ^ 8'hC3 : lo;
    endfunction

    task automatic t_regs();
        bus(`FTA_OFF_CTRL, 1'b0, 8'h00, r);
        chk(r, 32'h0);
        wr(`FTA_OFF_CTRL, 8'hF9);
        bus(`FTA_OFF_CTRL, 1'b0, 8'h00, r);
        chk(r, 32'h18);
        wr(`FTA_OFF_CTRL, 8'h00);
        wr(`FTA_OFF_LATCH, 8'hA5);
        bus(`FTA_OFF_LATCH, 1'b0, 8'h00, r);
        chk(r, 32'hA5);
        wr(`FTA_OFF_PTR_UPPER, 8'hFF);
        bus(`FTA_OFF_PTR_UPPER, 1'b0, 8'h00, r);
        chk(r, 32'h3F);
        bus(`FTA_OFF_UNLOCK, 1'b0, 8'h00, r);
        chk(r, 32'h0);
        bus(5'h1C, 1'b0, 8'h00, r);
        chk(r, 32'h0);
        chk({31'h0, hresp}, 32'h0);
    endtask

    // One table operation in mode m, read (w=0) or write (w=1)
    task automatic tbl(input logic [1:0] m, input logic w);
        logic [21:0] a;
        logic [31:0] u;
        logic [31:0] h;
        if (m == 2'h3) p = {p[21], p[20:0] + 21'h1};
        a = p;
        if (m == 2'h1) p = {p[21], p[20:0] + 21'h1};
        if (m == 2'h2) p = {p[21], p[20:0] - 21'h1};
        bus(`FTA_OFF_TABLE_CMD, 1'b1, {5'h0, w, m}, r);
        if (!w)
        begin
            bus(`FTA_OFF_LATCH, 1'b0, 8'h00, r);
            chk(r, {24'h0, byte_at(a)});
        end
        else
        begin
            hold_rd_idx <= a[5:0];
            @(posedge hclk);
            chk(hold_rd_data, 8'hA5);
        end
        bus(`FTA_OFF_PTR_UPPER, 1'b0, 8'h00, u);
        bus(`FTA_OFF_PTR_HIGH, 1'b0, 8'h00, h);
        bus(`FTA_OFF_PTR_LOW, 1'b0, 8'h00, r);
        chk({u[5:0], h[7:0], r[7:0]}, p);
    endtask

    task automatic t_table();
        wr(`FTA_OFF_PTR_HIGH, 8'hFF);
        wr(`FTA_OFF_PTR_LOW, 8'hFF);
        p = 22'h3FFFFF;
        for (int i = 1; i <= 4; i++) tbl(i[1:0], 1'b0);
        // Reads above replaced the latch; reload the byte the writes expect
        wr(`FTA_OFF_LATCH, 8'hA5);
        tbl(2'h2, 1'b1);
        tbl(2'h3, 1'b1);
    endtask

    // Self-timed cycle: er=1 erase, er=0 program; error preset so completion must clear it
    task automatic t_cycle(input logic er);
        wr(`FTA_OFF_CTRL, {3'h0, er, 4'h4});
        unlock();
        n_prog = 0;
        n_erase = 0;
        n_stall = 0;
        wr(`FTA_OFF_CTRL, {3'h0, er, 4'hE});
        bus(`FTA_OFF_CTRL, 1'b0, 8'h00, r);
        chk(r, 32'h04);
        chk(n_erase, {31'h0, er});
        chk(n_prog, {31'h0, ~er});
        chk(n_stall, PROG);
        chk(blk, p[21:10]);
        chk(hold_rd_data, 8'hA5);
    endtask

    // Refused starts: no enable, broken unlock, no unlock
    task automatic t_refuse(input int k);
        n_prog = 0;
        n_erase = 0;
        if (k != 2) wr(`FTA_OFF_UNLOCK, `FTA_KEY_FIRST);
        if (k == 1) wr(`FTA_OFF_LATCH, 8'hA5);
        if (k != 2) wr(`FTA_OFF_UNLOCK, `FTA_KEY_SECOND);
        wr(`FTA_OFF_CTRL, (k == 0) ? 8'h02 : 8'h06);
        repeat (PROG + 4) @(posedge hclk);
        bus(`FTA_OFF_CTRL, 1'b0, 8'h00, r);
        chk(r, (k == 0) ? 32'h08 : 32'h0C);
        chk(n_prog + n_erase, 0);
        wr(`FTA_OFF_CTRL, 8'h00);
    endtask

    // Warm reset in mid-cycle aborts it and flags the error
    task automatic t_abort();
        int n;
        wr(`FTA_OFF_CTRL, 8'h04);
        unlock();
        wr(`FTA_OFF_CTRL, 8'h06);
        n = 0;
        while (fetch_stall !== 1'b1 && n < 50)
        begin
            @(posedge hclk);
            n++;
        end
        warm_reset <= 1'b1;
        @(posedge hclk);
        warm_reset <= 1'b0;
        bus(`FTA_OFF_CTRL, 1'b0, 8'h00, r);
        chk(r, 32'h08);
        chk(fetch_stall, 1'b0);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_table();
        t_cycle(1'b0);
        t_cycle(1'b1);
        for (int k = 0; k < 3; k++) t_refuse(k);
        t_abort();
        final_report();
    end
endmodule
